// [src/kgas_cfg.svh]
// Register map, field positions, reset values and timing counts.
// Assumes inclusion by the keypad output, repeat and sleep block.
`ifndef KGAS_CFG_SVH
`define KGAS_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define KGAS_ADDR_CFG 8'h01
`define KGAS_ADDR_PORTS 8'h04
`define KGAS_ADDR_REP 8'h05
`define KGAS_ADDR_IDLE 8'h06

// ----------------------------------------
// Field positions
// ----------------------------------------
`define KGAS_CFG_AWAKE 7
`define KGAS_CFG_WAKE 1
`define KGAS_REP_EN 7
`define KGAS_REP_RATE_HI 6
`define KGAS_REP_RATE_LO 4
`define KGAS_REP_DLY_HI 3
`define KGAS_REP_DLY_LO 0
`define KGAS_IDLE_HI 2
`define KGAS_IDLE_LO 0

// ----------------------------------------
// Reset values and repeat code
// ----------------------------------------
`define KGAS_CFG_RST 8'h82
`define KGAS_PORTS_RST 8'hFE
`define KGAS_REP_RST 8'h00
`define KGAS_IDLE_RST 8'h07
`define KGAS_REPEAT_CODE 8'h7E

// ----------------------------------------
// Timing
// ----------------------------------------
`define KGAS_CLK_HZ 10000000
`define KGAS_MS_CYCLES (`KGAS_CLK_HZ / 1000)
`define KGAS_DEB_MIN_MS 9
`define KGAS_PWRUP_MS 2
`define KGAS_DLY_STEP 8
`define KGAS_RATE_STEP 4
`define KGAS_IDLE_MAX_MS 8192
`define KGAS_IDLE_MIN_MS 256

`endif

// [src/kgas_pkg.sv]
// Types shared by the keypad output, repeat and sleep block.
// Assumes kgas_cfg.svh for all numeric constants.
package kgas_pkg;

	typedef enum logic [1:0] {
		KGAS_RUN = 2'b00,
		KGAS_SLEEP = 2'b01,
		KGAS_PWRUP = 2'b10
	} kgas_state_type;

	typedef enum logic {
		KGAS_PH_DELAY = 1'b0,
		KGAS_PH_RATE = 1'b1
	} kgas_phase_type;

	// Register access from the serial engine
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} kgas_req_type;

	// Open-drain output pins; oe high while pulling low
	typedef struct packed {
		logic [5:0] col_out;
		logic [5:0] col_oe;
		logic int_out;
		logic int_oe;
	} kgas_pins_type;

endpackage

// [src/kgas_timebase.sv]
// Millisecond tick and debounce-cycle tick generator.
// Assumes a free running system clock and a synchronised reset.
`timescale 1ns/1ps
`include "kgas_cfg.svh"
module kgas_timebase #(
	parameter int MS_CYCLES = `KGAS_MS_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Control
	input wire logic [4:0] deb_time,
	input wire logic run,
	// Ticks
	output logic ms_tick,
	output logic deb_tick
);
	import kgas_pkg::*;

	localparam int MW = $clog2(MS_CYCLES + 1);
	localparam logic [5:0] DEB_MIN = 6'(`KGAS_DEB_MIN_MS);

	logic [MW-1:0] ms_q;
	logic [5:0] deb_q;
	wire ms_end = ms_q == MW'(MS_CYCLES - 1);
	// Debounce cycle is 9 ms plus the field value; >= so that a
	// shorter setting ends the running cycle instead of wrapping
	wire [5:0] deb_lim = DEB_MIN + {1'b0, deb_time};
	wire deb_end = ms_end && (deb_q >= deb_lim - 6'h01);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_q <= '0;
			deb_q <= 6'h00;
		end else if (clk_en) begin
			ms_q <= ms_end ? '0 : ms_q + MW'(1);
			if (!run || deb_end)
				deb_q <= 6'h00;
			else if (ms_end)
				deb_q <= deb_q + 6'h01;
		end
	end

	assign ms_tick = clk_en && ms_end;
	assign deb_tick = clk_en && run && deb_end;

endmodule

// [src/kgas_top.sv]
// Keypad general outputs, key autorepeat and sleep control.
// Assumes a serial engine presenting register writes and a read
// address, and a matrix scanner reporting key events on sys_clk.
`timescale 1ns/1ps
`include "kgas_cfg.svh"
module kgas_top #(
	parameter int MS_CYCLES = `KGAS_MS_CYCLES
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// Register port
	input wire kgas_pkg::kgas_req_type req,
	output logic [7:0] rdata,
	// Settings held elsewhere
	input wire logic [4:0] deb_time,
	input wire logic [2:0] ports_enable,
	input wire logic int_is_gpo,
	// Scanner side
	input wire logic key_event,
	input wire logic key_held,
	input wire logic wake_key_n,
	output logic rep_push,
	output logic [7:0] rep_code,
	output logic scan_power,
	output logic scan_run,
	output logic matrix_pullup,
	// Open-drain outputs
	output kgas_pkg::kgas_pins_type pins
);
	import kgas_pkg::*;

	// ----------------------------------------
	// Reset release and pin synchroniser
	// ----------------------------------------
	logic rst_meta, rst_n;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	logic wk_meta, wk_n;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wk_meta <= 1'b1;
			wk_n <= 1'b1;
		end else if (clk_en) begin
			wk_meta <= wake_key_n;
			wk_n <= wk_meta;
		end
	end

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	// Ports enable field: grows downward from port 7
	function automatic logic [5:0] gpo_mask(input logic [2:0] code);
		logic [5:0] m;
		m = 6'h00;
		for (int i = 0; i < 6; i++)
			if (code >= 3'(6 - i))
				m[i] = 1'b1;
		return m;
	endfunction

	function automatic logic [13:0] idle_lim(input logic [2:0] code);
		logic [13:0] v;
		v = 14'h0000;
		if (code == 3'h7)
			v = 14'(`KGAS_IDLE_MIN_MS);
		else if (code != 3'h0)
			v = 14'(`KGAS_IDLE_MAX_MS) >> (code - 3'h1);
		return v;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] cfg_q, ports_q, rep_q, idle_q;
	kgas_state_type st_q, st_d;

	wire wr_en = clk_en && req.wr;
	wire wr_cfg = wr_en && req.addr == `KGAS_ADDR_CFG;
	wire wr_ports = wr_en && req.addr == `KGAS_ADDR_PORTS;
	wire wr_rep = wr_en && req.addr == `KGAS_ADDR_REP;
	wire wr_idle = wr_en && req.addr == `KGAS_ADDR_IDLE;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= `KGAS_CFG_RST;
			ports_q <= `KGAS_PORTS_RST;
			rep_q <= `KGAS_REP_RST;
			idle_q <= `KGAS_IDLE_RST;
		end else begin
			if (wr_cfg)
				cfg_q <= req.wdata;
			if (wr_ports)
				ports_q <= {req.wdata[7:1], 1'b0};
			if (wr_rep)
				rep_q <= req.wdata;
			if (wr_idle)
				idle_q <= {5'h00, req.wdata[`KGAS_IDLE_HI:`KGAS_IDLE_LO]};
		end
	end

	wire awake = st_q != KGAS_SLEEP;
	wire wake_en = cfg_q[`KGAS_CFG_WAKE];
	wire [7:0] cfg_rd = {awake, cfg_q[6:0]};

	// Stored value, never the pin level
	wire [7:0] rd_mux =
		(req.addr == `KGAS_ADDR_CFG) ? cfg_rd :
		(req.addr == `KGAS_ADDR_PORTS) ? ports_q :
		(req.addr == `KGAS_ADDR_REP) ? rep_q :
		(req.addr == `KGAS_ADDR_IDLE) ? idle_q : 8'h00;

	logic [7:0] rdata_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else if (clk_en)
			rdata_q <= rd_mux;
	end
	assign rdata = rdata_q;

	// ----------------------------------------
	// General purpose outputs
	// ----------------------------------------
	wire [5:0] gpo_en = gpo_mask(ports_enable);
	kgas_pins_type pins_q;
	logic [5:0] col_oe_d;

	// Pins left to scanning keep oe low
	generate
		for (genvar i = 0; i < 6; i++) begin : g_col
			assign col_oe_d[i] = gpo_en[i] && !ports_q[i + 2];
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_q <= '0;
		end else if (clk_en) begin
			pins_q.col_out <= 6'h00;
			pins_q.col_oe <= col_oe_d;
			pins_q.int_out <= 1'b0;
			pins_q.int_oe <= int_is_gpo && !ports_q[1];
		end
	end
	assign pins = pins_q;

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	logic ms_tick, deb_tick;
	kgas_timebase #(
		.MS_CYCLES(MS_CYCLES)
	) u_tb (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.deb_time(deb_time),
		.run(st_q == KGAS_RUN),
		.ms_tick(ms_tick),
		.deb_tick(deb_tick)
	);

	// ----------------------------------------
	// Autorepeat
	// ----------------------------------------
	logic [7:0] cnt_q;
	kgas_phase_type ph_q;
	logic push_q;

	wire rep_en = rep_q[`KGAS_REP_EN];
	wire [4:0] dly_n = {1'b0, rep_q[`KGAS_REP_DLY_HI:`KGAS_REP_DLY_LO]};
	wire [3:0] rate_n = {1'b0, rep_q[`KGAS_REP_RATE_HI:`KGAS_REP_RATE_LO]};
	wire [7:0] dly_lim = {dly_n + 5'h01, 3'b000};
	wire [7:0] rate_lim = {2'b00, rate_n + 4'h1, 2'b00};
	wire [7:0] lim = (ph_q == KGAS_PH_RATE) ? rate_lim : dly_lim;
	wire rep_live = rep_en && key_held && st_q == KGAS_RUN;
	wire hit = deb_tick && cnt_q + 8'h01 == lim;

	// One counter for all held keys gives one code per interval
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			ph_q <= KGAS_PH_DELAY;
			push_q <= 1'b0;
		end else if (clk_en) begin
			push_q <= 1'b0;
			if (!rep_live || key_event) begin
				cnt_q <= 8'h00;
				ph_q <= KGAS_PH_DELAY;
			end else if (hit) begin
				cnt_q <= 8'h00;
				ph_q <= KGAS_PH_RATE;
				push_q <= 1'b1;
			end else if (deb_tick) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
	// Only the repeat code leaves; release restarts
	assign rep_push = push_q;
	assign rep_code = `KGAS_REPEAT_CODE;

	// ----------------------------------------
	// Sleep control
	// ----------------------------------------
	logic [13:0] idle_cnt_q;
	logic [1:0] pu_q;
	wire [13:0] i_lim = idle_lim(idle_q[`KGAS_IDLE_HI:`KGAS_IDLE_LO]);
	wire idle_run = st_q == KGAS_RUN && !key_held && i_lim != 14'h0000;
	wire idle_hit = idle_run && ms_tick && idle_cnt_q + 14'h0001 == i_lim;
	// Free tick phase: wait one extra tick so a full 2 ms elapses
	wire pu_done = ms_tick && pu_q == 2'(`KGAS_PWRUP_MS);

	always_comb begin
		st_d = st_q;
		case (st_q)
			KGAS_RUN: begin
				if (idle_hit)
					st_d = KGAS_SLEEP;
			end
			KGAS_SLEEP: begin
				if (wake_en && !wk_n)
					st_d = KGAS_PWRUP;
			end
			KGAS_PWRUP: begin
				if (pu_done)
					st_d = KGAS_RUN;
			end
			default: st_d = KGAS_RUN;
		endcase
		// Host write takes priority over automatic moves, except an awake write in KGAS_RUN, where idle_hit still wins
		if (wr_cfg && !req.wdata[`KGAS_CFG_AWAKE])
			st_d = KGAS_SLEEP;
		else if (wr_cfg && st_q != KGAS_RUN)
			st_d = KGAS_RUN;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= KGAS_RUN;
			idle_cnt_q <= 14'h0000;
			pu_q <= 2'b00;
		end else if (clk_en) begin
			st_q <= st_d;
			if (!idle_run || idle_hit)
				idle_cnt_q <= 14'h0000;
			else if (ms_tick)
				idle_cnt_q <= idle_cnt_q + 14'h0001;
			if (st_q != KGAS_PWRUP)
				pu_q <= 2'b00;
			else if (ms_tick)
				pu_q <= pu_q + 2'b01;
		end
	end

	// FIFO is outside and never flushed here
	assign scan_power = st_q != KGAS_SLEEP;
	assign matrix_pullup = st_q == KGAS_SLEEP;
	// Scanner debounces only after power-up; wake key kept held
	assign scan_run = st_q == KGAS_RUN;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_gpo_only;
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !gpo_en[0] |=> !pins.col_oe[0];
	endproperty
	a_gpo_only: assert property (p_gpo_only)
		else $error("column oe while pin scans");
	property p_port_rd;
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && req.addr == `KGAS_ADDR_PORTS
		|=> rdata == $past(ports_q);
	endproperty
	a_port_rd: assert property (p_port_rd)
		else $error("port read not stored value");
	property p_bit0;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_ports |=> ports_q[0] == 1'b0 && ports_q[1] == $past(req.wdata[1]);
	endproperty
	a_bit0: assert property (p_bit0)
		else $error("port bit layout wrong");
	property p_rep_off;
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !rep_en |=> cnt_q == 8'h00 && !rep_push;
	endproperty
	a_rep_off: assert property (p_rep_off)
		else $error("repeat active while disabled");
	sequence s_delay_end;
		clk_en && rep_live && !key_event && deb_tick &&
		ph_q == KGAS_PH_DELAY && cnt_q + 8'h01 == dly_lim;
	endsequence
	property p_delay_push;
		@(posedge sys_clk) disable iff (!rst_n)
		s_delay_end |=> rep_push ##1 !rep_push;
	endproperty
	a_delay_push: assert property (p_delay_push)
		else $error("repeat code missing after delay");
	property p_event_restart;
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && key_event
		|=> cnt_q == 8'h00 && ph_q == KGAS_PH_DELAY && !rep_push;
	endproperty
	a_event_restart: assert property (p_event_restart)
		else $error("key event did not restart repeat");
	property p_sleep_wr;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_cfg && !req.wdata[`KGAS_CFG_AWAKE]
		|=> st_q == KGAS_SLEEP && matrix_pullup && !scan_power;
	endproperty
	a_sleep_wr: assert property (p_sleep_wr)
		else $error("sleep write ignored");

	property p_no_wake;
		@(posedge sys_clk) disable iff (!rst_n)
		st_q == KGAS_SLEEP && !wake_en && !wr_cfg |=> st_q == KGAS_SLEEP;
	endproperty
	a_no_wake: assert property (p_no_wake)
		else $error("woke with wake disabled");
	property p_pwrup;
		@(posedge sys_clk) disable iff (!rst_n)
		st_q == KGAS_PWRUP && !wr_cfg && !pu_done |=> st_q == KGAS_PWRUP;
	endproperty
	a_pwrup: assert property (p_pwrup)
		else $error("power-up cut short");

	property p_cfg_rd;
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && req.addr == `KGAS_ADDR_CFG
		|=> rdata[7] == $past(awake);
	endproperty
	a_cfg_rd: assert property (p_cfg_rd)
		else $error("config bit 7 not sleep state");

endmodule

// [testbench/kgas_scan_model.sv]
// Keypad matrix and scanner stand-in facing the repeat and sleep block.
// Assumes the bench pulses press or release_key for one cycle.
`timescale 1ns/1ps
module kgas_scan_model (
	// Clock
	input wire logic sys_clk,
	// Bench commands
	input wire logic press,
	input wire logic release_key,
	// Block side
	input wire logic scan_run,
	output logic key_event,
	output logic key_held,
	output logic wake_key_n
);
	int unsigned held_q = 0;
	// Events only recorded while scanning runs; asleep keys still count in held_q and pull wake_key_n
	always @(posedge sys_clk) begin
		if (press)
			held_q <= held_q + 1;
		else if (release_key && held_q != 0)
			held_q <= held_q - 1;
		key_event <= scan_run && (press || release_key);
	end
	assign key_held = scan_run && held_q != 0;
	// A pressed key pulls its line below the sleep pull-up
	assign wake_key_n = (held_q == 0);
endmodule

// [testbench/tb.sv]
// Self-checking bench for the keypad output, repeat and sleep block.
// Assumes the scanner model and a shortened millisecond count.
`timescale 1ns/1ps
module tb;
	import kgas_pkg::*;
	localparam int MSC = 10;
	localparam int DEB = 9 * MSC;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	kgas_req_type req = '0;
	logic [7:0] rdata, rep_code;
	logic [2:0] ports_enable = 3'h6;
	logic [4:0] deb_time = 5'h00;
	logic int_is_gpo = 1'b1;
	logic press = 1'b0;
	logic release_key = 1'b0;
	logic key_event, key_held, wake_key_n, rep_push;
	logic scan_power, scan_run, matrix_pullup;
	kgas_pins_type pins;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int t_evt = 0;
	int n;
	int pushes[$];

	always #50 sys_clk = ~sys_clk;

	kgas_top #(.MS_CYCLES(MSC)) dut (
		.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.req(req), .rdata(rdata), .deb_time(deb_time),
		.ports_enable(ports_enable), .int_is_gpo(int_is_gpo),
		.key_event(key_event), .key_held(key_held),
		.wake_key_n(wake_key_n), .rep_push(rep_push),
		.rep_code(rep_code), .scan_power(scan_power),
		.scan_run(scan_run), .matrix_pullup(matrix_pullup),
		.pins(pins)
	);
	kgas_scan_model scan (
		.sys_clk(sys_clk), .press(press), .release_key(release_key),
		.scan_run(scan_run), .key_event(key_event),
		.key_held(key_held), .wake_key_n(wake_key_n)
	);

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (rep_push)
			pushes.push_back(cyc);
		if (key_event)
			t_evt <= cyc;
	end

	// ----------------------------------------
	// Compare and access tasks
	// ----------------------------------------
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic chk_in(string what, int lo, int hi, int got);
		n_compared++;
		if (got < lo || got > hi) begin
			failures++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi,
				got);
		end
	endtask
	task automatic reg_wr(logic [7:0] a, logic [7:0] d);
		@(posedge sys_clk);
		req <= '{wr: 1'b1, addr: a, wdata: d};
		@(posedge sys_clk);
		req.wr <= 1'b0;
	endtask
	task automatic reg_chk(string what, logic [7:0] a, logic [7:0] exp);
		@(posedge sys_clk);
		req.addr <= a;
		repeat (2) @(posedge sys_clk);
		chk(what, exp, rdata);
	endtask
	task automatic key(bit down);
		@(posedge sys_clk);
		if (down)
			press <= 1'b1;
		else
			release_key <= 1'b1;
		@(posedge sys_clk);
		press <= 1'b0;
		release_key <= 1'b0;
	endtask
	task automatic wait_push(int k);
		int w;
		w = 0;
		while (pushes.size() < k && w < 8000) begin
			@(posedge sys_clk);
			w++;
		end
		chk("pushes", 8'(k), 8'(pushes.size()));
	endtask
	function automatic logic [5:0] gpo_mask(logic [2:0] pe);
		int m;
		m = (pe >= 3'h6) ? 6 : int'(pe);
		gpo_mask = 6'h3F << (6 - m);
	endfunction
	task automatic final_report();
		$display("Compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge sys_clk);
		failures++;
		$display("Error watchdog expected done seen timeout");
		final_report();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		reg_chk("cfg", 8'h01, 8'h82);
		reg_chk("ports", 8'h04, 8'hFE);
		reg_chk("repeat", 8'h05, 8'h00);
		reg_chk("idle", 8'h06, 8'h07);
		reg_chk("unmapped", 8'h02, 8'h00);
		reg_wr(8'h06, 8'h00);
		$display("Test reset values done");

		reg_wr(8'h04, 8'h0F);
		reg_chk("ports rb", 8'h04, 8'h0E);
		chk("col_oe", {2'h0, 6'h3C}, {2'h0, pins.col_oe});
		chk("int_oe", 8'h00, {7'h0, pins.int_oe});
		reg_wr(8'h04, 8'h00);
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			ports_enable <= i[2:0];
			int_is_gpo <= i[0];
			repeat (3) @(posedge sys_clk);
			chk("col_oe", {2'h0, gpo_mask(i[2:0])}, {2'h0, pins.col_oe});
			chk("int_oe", {7'h0, i[0]}, {7'h0, pins.int_oe});
			chk("col_out", 8'h00, {2'h0, pins.col_out});
			chk("int_out", 8'h00, {7'h0, pins.int_out});
		end
		reg_wr(8'h04, 8'hFE);
		$display("Test output port done");

		reg_wr(8'h05, 8'h80);
		key(1'b1);
		wait_push(2);
		chk_in("delay", 7 * DEB, 8 * DEB + 3, pushes[0] - t_evt);
		chk_in("rate", 4 * DEB - 1, 4 * DEB + 1, pushes[1] - pushes[0]);
		key(1'b1);
		wait_push(4);
		chk_in("new event", 7 * DEB, 8 * DEB + 3, pushes[2] - t_evt);
		chk_in("two keys", 4 * DEB - 1, 4 * DEB + 1, pushes[3] - pushes[2]);
		key(1'b0);
		wait_push(5);
		chk_in("restart", 7 * DEB, 8 * DEB + 3, pushes[4] - t_evt);
		chk("code", 8'h7E, rep_code);
		reg_wr(8'h05, 8'h00);
		pushes.delete();
		repeat (12 * DEB) @(posedge sys_clk);
		chk("disabled", 8'h00, 8'(pushes.size()));
		reg_wr(8'h05, 8'hA1);
		key(1'b1);
		wait_push(2);
		chk_in("delay 16", 15 * DEB, 16 * DEB + 3, pushes[0] - t_evt);
		chk_in("rate 12", 12 * DEB - 1, 12 * DEB + 1, pushes[1] - pushes[0]);
		deb_time <= 5'h1F;
		reg_wr(8'h05, 8'h80);
		pushes.delete();
		key(1'b0);
		wait_push(2);
		chk_in("delay 40ms", 280 * MSC, 320 * MSC + 3,
			pushes[0] - t_evt);
		chk_in("rate 40ms", 160 * MSC - 1, 160 * MSC + 1,
			pushes[1] - pushes[0]);
		key(1'b0);
		deb_time <= 5'h00;
		reg_wr(8'h05, 8'h00);
		$display("Test autorepeat done");

		reg_wr(8'h01, 8'h02);
		reg_chk("cfg sleep", 8'h01, 8'h02);
		chk("pullup", 8'h01, {7'h0, matrix_pullup});
		chk("power", 8'h00, {7'h0, scan_power});
		key(1'b1);
		repeat (6) @(posedge sys_clk);
		chk("powerup", 8'h02, {6'h0, scan_power, scan_run});
		n = 6;
		while (scan_run !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		chk_in("wake time", 2 * MSC + 4, 3 * MSC + 4, n);
		reg_chk("cfg awake", 8'h01, 8'h82);
		key(1'b0);
		reg_wr(8'h01, 8'h00);
		key(1'b1);
		repeat (40) @(posedge sys_clk);
		chk("no wake", 8'h00, {7'h0, scan_power});
		reg_wr(8'h01, 8'h80);
		reg_chk("host wake", 8'h01, 8'h80);
		key(1'b0);
		$display("Test sleep done");

		reg_wr(8'h06, 8'h06);
		n = 0;
		while (scan_power !== 1'b0 && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		chk_in("autosleep", 256 * MSC - 60, 256 * MSC + 20, n);
		reg_chk("cfg auto", 8'h01, 8'h00);
		reg_wr(8'h01, 8'h80);
		reg_wr(8'h06, 8'h00);
		$display("Test autosleep done");
		final_report();
	end
endmodule
